// >>> common/pcint_regs.svh
`ifndef PCINT_REGS_SVH
`define PCINT_REGS_SVH

// ----------------------------------------
// Register indices, byte address is index * 4
// ----------------------------------------
`define PCINT_IDX_CONTROL 8'hE9
`define PCINT_IDX_FALL_EN 8'hEA
`define PCINT_IDX_RISE_EN 8'hEB
`define PCINT_IDX_FLAGS 8'hEC
`define PCINT_IDX_IRQ_STATUS 8'hED
`define PCINT_IDX_IRQ_CLEAR 8'hEE
`define PCINT_IDX_IRQ_ENABLE 8'hEF

// ----------------------------------------
// Field positions in the control register
// ----------------------------------------
`define PCINT_CTL_PORT_LSB 0
`define PCINT_CTL_PORT_MSB 1
`define PCINT_CTL_TYPE0 2
`define PCINT_CTL_TYPE1 3
`define PCINT_CTL_TYPE2 4
`define PCINT_CTL_TYPE3 5
`define PCINT_CTL_TYPE45 6
`define PCINT_CTL_TYPE67 7

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define PCINT_RST_CONTROL 8'h00
`define PCINT_RST_FALL_EN 8'h00
`define PCINT_RST_RISE_EN 8'h00
`define PCINT_RST_FLAGS 8'h00
`define PCINT_RST_IRQ 8'h00
`define PCINT_RESP_OKAY 2'h0
`define PCINT_RESP_SLVERR 2'h2

`endif

// >>> common/pcint_pkg.sv
`default_nettype none

package pcint_pkg;
  // Trigger type of a channel
  typedef enum logic {
    PCINT_LEVEL = 1'b0,
    PCINT_EDGE = 1'b1
  } pcint_trig_t;

  // Source port code
  typedef enum logic [1:0] {
    PCINT_PORT0 = 2'b00,
    PCINT_PORT1 = 2'b01,
    PCINT_PORT2 = 2'b10,
    PCINT_PORT3 = 2'b11
  } pcint_port_t;
endpackage

`default_nettype wire

// >>> design/pcint_chan.sv
`default_nettype none

module pcint_chan
  import pcint_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Sampled pin
  input wire logic pinNow,
  input wire logic pinPrev,
  // Configuration
  input wire pcint_trig_t trigType,
  input wire logic fallEn,
  input wire logic riseEn,
  // Software clear of an edge flag
  input wire logic clrFlag,
  // Results
  output logic flag,
  output logic event_,
  output logic request
);
  // ----------------------------------------
  // Detection
  // ----------------------------------------
  logic levelHit;
  logic edgeHit;

  // Enabled level or edge seen this cycle
  always_comb begin
    levelHit = (fallEn & ~pinNow) | (riseEn & pinNow);
    edgeHit = (fallEn & pinPrev & ~pinNow) | (riseEn & ~pinPrev & pinNow);
    event_ = (trigType == PCINT_EDGE) ? edgeHit : levelHit;
    request = (trigType == PCINT_EDGE) ? flag : levelHit;
  end

  // ----------------------------------------
  // Flag
  // ----------------------------------------
  // Set beats clear so an edge during a clear write is kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (trigType == PCINT_LEVEL) begin
      flag <= ~pinNow;
    end else if (edgeHit) begin
      flag <= 1'b1;
    end else if (clrFlag) begin
      flag <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> design/pcint_top.sv
`include "pcint_regs.svh"
`default_nettype none

module pcint_top
  import pcint_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,

  // Candidate pin ports
  input wire logic [CHANNELS-1:0] port0,
  input wire logic [CHANNELS-1:0] port1,
  input wire logic [CHANNELS-1:0] port2,
  input wire logic [CHANNELS-1:0] port3,

  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,

  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,

  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // Interrupt and wake outputs
  output logic pinIrqReq,
  output logic wakeReq,
  output logic irq
);
  // ----------------------------------------
  // Byte addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'({`PCINT_IDX_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_FALL_EN = ADDR_W'({`PCINT_IDX_FALL_EN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_RISE_EN = ADDR_W'({`PCINT_IDX_RISE_EN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'({`PCINT_IDX_FLAGS, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'({`PCINT_IDX_IRQ_STATUS, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = ADDR_W'({`PCINT_IDX_IRQ_CLEAR, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'({`PCINT_IDX_IRQ_ENABLE, 2'b00});

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] pinIrqControl;
  logic [7:0] pinIrqFallingEnable;
  logic [7:0] pinIrqRisingEnable;
  logic [7:0] irqStatus;
  logic [7:0] irqEnable;
  logic [7:0] channelFlag;
  logic [7:0] channelEvent;
  logic [7:0] channelReq;
  logic [7:0] flagClear;
  logic [7:0] selPort;
  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic [7:0] pinLast;
  pcint_trig_t [7:0] typeSel;
  pcint_port_t portSelect;

  // Write channel holding state
  logic awFull;
  logic wFull;
  logic [ADDR_W-1:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  logic wrGo;
  logic next_awFull;
  logic next_wFull;
  logic next_bvalid;

  // Read channel state and address decode hits
  logic arTake;
  logic next_rvalid;
  logic [31:0] readWord;
  logic readHit;
  logic writeHit;

  // ----------------------------------------
  // Port select and pin synchroniser
  // ----------------------------------------
  assign portSelect = pcint_port_t'(pinIrqControl[`PCINT_CTL_PORT_MSB:`PCINT_CTL_PORT_LSB]);

  // Choose the port before sampling, saving three banks of flops
  always_comb begin
    if (portSelect == PCINT_PORT0) begin
      selPort = port0;
    end else if (portSelect == PCINT_PORT1) begin
      selPort = port1;
    end else if (portSelect == PCINT_PORT2) begin
      selPort = port2;
    end else begin
      selPort = port3;
    end
  end

  // Two stages against metastability, third keeps the previous level.
  // Changing the port select can look like an edge two cycles later, once the new port reaches pinSync.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
      pinLast <= 8'h00;
    end else begin
      pinMeta <= selPort;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // ----------------------------------------
  // Trigger type per channel
  // ----------------------------------------
  // Upper channels share their type bit in pairs
  always_comb begin
    typeSel[0] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE0]);
    typeSel[1] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE1]);
    typeSel[2] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE2]);
    typeSel[3] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE3]);
    typeSel[4] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE45]);
    typeSel[5] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE45]);
    typeSel[6] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE67]);
    typeSel[7] = pcint_trig_t'(pinIrqControl[`PCINT_CTL_TYPE67]);
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  // One detector per channel, each with its own flag
  for (genvar n = 0; n < 8; n++) begin : g_chan
    pcint_chan u_chan (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pinNow(pinSync[n]),
      .pinPrev(pinLast[n]),
      .trigType(typeSel[n]),
      .fallEn(pinIrqFallingEnable[n]),
      .riseEn(pinIrqRisingEnable[n]),
      .clrFlag(flagClear[n]),
      .flag(channelFlag[n]),
      .event_(channelEvent[n]),
      .request(channelReq[n])
    );
  end

  // ----------------------------------------
  // Pin request and wake
  // ----------------------------------------
  // Detection runs on sys_clk, so that clock must stay on in
  // power-down for the wake to work; the request is a plain level.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinIrqReq <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      pinIrqReq <= |channelReq;
      wakeReq <= |channelReq;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign wrGo = awFull & wFull & ~s_axi_bvalid;
  assign writeHit = (awAddr == ADDR_CONTROL) || (awAddr == ADDR_FALL_EN) ||
                    (awAddr == ADDR_RISE_EN) || (awAddr == ADDR_FLAGS) ||
                    (awAddr == ADDR_IRQ_STATUS) || (awAddr == ADDR_IRQ_CLEAR) ||
                    (awAddr == ADDR_IRQ_ENABLE);

  // Next state of the two holding slots and the response
  always_comb begin
    next_awFull = awFull;
    next_wFull = wFull;
    next_bvalid = s_axi_bvalid;
    if (wrGo) begin
      next_awFull = 1'b0;
      next_wFull = 1'b0;
      next_bvalid = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_awFull = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wFull = 1'b1;
    end
  end

  // Address and data are taken in either order and held
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awFull <= 1'b0;
      wFull <= 1'b0;
      awAddr <= '0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      awFull <= next_awFull;
      wFull <= next_wFull;
      s_axi_awready <= ~next_awFull;
      s_axi_wready <= ~next_wFull;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
    end
  end

  // Response once both halves are in
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCINT_RESP_OKAY;
    end else begin
      s_axi_bvalid <= next_bvalid;
      if (wrGo) begin
        s_axi_bresp <= writeHit ? `PCINT_RESP_OKAY : `PCINT_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Only byte lane 0 carries register data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinIrqControl <= `PCINT_RST_CONTROL;
      pinIrqFallingEnable <= `PCINT_RST_FALL_EN;
      pinIrqRisingEnable <= `PCINT_RST_RISE_EN;
      irqEnable <= `PCINT_RST_IRQ;
    end else if (wrGo && wLane0) begin
      if (awAddr == ADDR_CONTROL) begin
        pinIrqControl <= wByte;
      end else if (awAddr == ADDR_FALL_EN) begin
        pinIrqFallingEnable <= wByte;
      end else if (awAddr == ADDR_RISE_EN) begin
        pinIrqRisingEnable <= wByte;
      end else if (awAddr == ADDR_IRQ_ENABLE) begin
        irqEnable <= wByte;
      end
    end
  end

  // Writing 0 to a flag bit clears it; level channels ignore this
  always_comb begin
    if (wrGo && wLane0 && (awAddr == ADDR_FLAGS)) begin
      flagClear = ~wByte;
    end else begin
      flagClear = 8'h00;
    end
  end

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  // Events set sticky bits; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= `PCINT_RST_IRQ;
    end else if (wrGo && wLane0 && (awAddr == ADDR_IRQ_CLEAR)) begin
      irqStatus <= (irqStatus & ~wByte) | channelEvent;
    end else begin
      irqStatus <= irqStatus | channelEvent;
    end
  end

  // Level output, high while an enabled status bit is set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqEnable);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign arTake = s_axi_arvalid & s_axi_arready;

  // Read mux; the clear register reads as zero
  always_comb begin
    readWord = 32'h0000_0000;
    readHit = 1'b1;
    if (s_axi_araddr[ADDR_W-1:2] == ADDR_CONTROL[ADDR_W-1:2]) begin
      readWord[7:0] = pinIrqControl;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_FALL_EN[ADDR_W-1:2]) begin
      readWord[7:0] = pinIrqFallingEnable;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_RISE_EN[ADDR_W-1:2]) begin
      readWord[7:0] = pinIrqRisingEnable;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_FLAGS[ADDR_W-1:2]) begin
      readWord[7:0] = channelFlag;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_IRQ_STATUS[ADDR_W-1:2]) begin
      readWord[7:0] = irqStatus;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_IRQ_CLEAR[ADDR_W-1:2]) begin
      readWord[7:0] = 8'h00;
    end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_IRQ_ENABLE[ADDR_W-1:2]) begin
      readWord[7:0] = irqEnable;
    end else begin
      readHit = 1'b0;
    end
  end

  // Next read valid
  always_comb begin
    next_rvalid = s_axi_rvalid;
    if (arTake) begin
      next_rvalid = 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Data captured at the address handshake and held until taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PCINT_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (arTake) begin
        s_axi_rdata <= readWord;
        s_axi_rresp <= readHit ? `PCINT_RESP_OKAY : `PCINT_RESP_SLVERR;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/pcint_top_sva.sv
`default_nettype none

module pcint_top_sva #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Requests
  input wire logic pinIrqReq,
  input wire logic wakeReq,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic arBad;
  logic awBad;
  logic wTake;
  // Unmapped means outside the seven aligned words
  assign arBad = !(s_axi_araddr >= 12'h3A4 && s_axi_araddr <= 12'h3BC && s_axi_araddr[1:0] == 2'b00);
  assign awBad = !(s_axi_awaddr >= 12'h3A4 && s_axi_awaddr <= 12'h3BC && s_axi_awaddr[1:0] == 2'b00);
  assign wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  wake_follows_a: assert property (wakeReq == pinIrqReq)
    else $error("wake differs from pin request");
  reset_quiet_a: assert property ($rose(rstn) |-> !irq && !pinIrqReq && !wakeReq)
    else $error("request high out of reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  // Write executes the edge after the take, so the answer shows one edge later
  write_answer_a: assert property (wTake |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && arBad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  write_unmapped_a: assert property (wTake && awBad |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write accepted");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind pcint_top pcint_top_sva #(.ADDR_W(ADDR_W)) pcint_top_sva_i (
  .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pinIrqReq(pinIrqReq), .wakeReq(wakeReq), .irq(irq));

`default_nettype wire

// >>> sim/pcint_pins_model.sv
`default_nettype none

module pcint_pins_model (
  // Pin ports
  output logic [7:0] port0,
  output logic [7:0] port1,
  output logic [7:0] port2,
  output logic [7:0] port3
);
  timeunit 1ns;
  timeprecision 1ns;
  // Keys idle high behind pull-ups, so level flags start clear
  logic [7:0] pins [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  assign port0 = pins[0];
  assign port1 = pins[1];
  assign port2 = pins[2];
  assign port3 = pins[3];
  // Caller is on a rising edge, so update non-blocking
  task automatic setPort(input int p, input logic [7:0] v);
    pins[p] <= v;
  endtask
endmodule

`default_nettype wire

// >>> sim/pcint_tb.sv
`include "pcint_regs.svh"
`default_nettype none

module pcint_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rstn = 0;
  logic [7:0] port0, port1, port2, port3;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pinIrqReq, wakeReq, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rd;
  int mismatches = 0, num_checks = 0, cycles = 0;

  pcint_pins_model pcint_pins_model_i (.port0(port0), .port1(port1), .port2(port2), .port3(port3));
  pcint_top pcint_top_i (.sys_clk(sys_clk), .rstn(rstn), .port0(port0), .port1(port1), .port2(port2),
    .port3(port3), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pinIrqReq(pinIrqReq), .wakeReq(wakeReq), .irq(irq));

  // ----------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run is well under 3000 cycles; a hang ends here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    awaddr <= ba(idx);
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (awvalid || wvalid);
    // Ready rises one edge after the answer, so the write answer waits one cycle for it
    @(posedge sys_clk);
    bready <= 1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rdw(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= ba(idx);
    arvalid <= 1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 0;
    @(posedge sys_clk);
    rready <= 1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    wr(idx, d, rs);
  endtask
  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
    rdw(idx, rd, rs);
    chk(rd, {24'h0, exp}, "register");
  endtask
  // Two sync stages, flag, then request
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) expect_reg(8'hE9 + i[7:0], 8'h00);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rdw(8'hF0, rd, rs);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(rs), 32'(`PCINT_RESP_SLVERR), "unmapped read");
    wr(8'hE8, 8'h55, rs);
    chk(32'(rs), 32'(`PCINT_RESP_SLVERR), "unmapped write");
    w(`PCINT_IDX_FALL_EN, 8'h5A);
    expect_reg(`PCINT_IDX_FALL_EN, 8'h5A);
    $display("test regs done");
    // Level mode: flags mirror inverted selected port only
    for (int p = 0; p < 4; p++) begin
      w(`PCINT_IDX_CONTROL, p[7:0]);
      pcint_pins_model_i.setPort(p, 8'h3C);
      settle();
      expect_reg(`PCINT_IDX_FLAGS, 8'hC3);
      w(`PCINT_IDX_FLAGS, 8'h00);
      expect_reg(`PCINT_IDX_FLAGS, 8'hC3);
      pcint_pins_model_i.setPort(p, 8'hFF);
    end
    $display("test port select done");
    // Ch0-3 edge, ch4-5 level, ch6-7 edge; fall on low half, rise on ch6-7
    w(`PCINT_IDX_CONTROL, 8'hBC);
    w(`PCINT_IDX_FALL_EN, 8'h0F);
    w(`PCINT_IDX_RISE_EN, 8'hC0);
    settle();
    w(`PCINT_IDX_FLAGS, 8'h00);
    w(`PCINT_IDX_IRQ_CLEAR, 8'hFF);
    expect_reg(`PCINT_IDX_FLAGS, 8'h00);
    expect_reg(`PCINT_IDX_CONTROL, 8'hBC);
    pcint_pins_model_i.setPort(0, 8'h00);
    settle();
    expect_reg(`PCINT_IDX_FLAGS, 8'h3F);
    pcint_pins_model_i.setPort(0, 8'hFF);
    settle();
    expect_reg(`PCINT_IDX_FLAGS, 8'hCF);
    w(`PCINT_IDX_FLAGS, 8'hFE);
    expect_reg(`PCINT_IDX_FLAGS, 8'hCE);
    w(`PCINT_IDX_FLAGS, 8'h00);
    expect_reg(`PCINT_IDX_FLAGS, 8'h00);
    $display("test edge done");
    // Raise, mask and clear the interrupt on channel 0
    w(`PCINT_IDX_IRQ_CLEAR, 8'hFF);
    w(`PCINT_IDX_IRQ_ENABLE, 8'h01);
    expect_reg(`PCINT_IDX_IRQ_ENABLE, 8'h01);
    chk({30'h0, irq, pinIrqReq}, 32'h0, "idle request");
    pcint_pins_model_i.setPort(0, 8'hFE);
    settle();
    chk({29'h0, irq, pinIrqReq, wakeReq}, 32'h7, "raised");
    expect_reg(`PCINT_IDX_IRQ_STATUS, 8'h01);
    w(`PCINT_IDX_IRQ_ENABLE, 8'h00);
    @(posedge sys_clk);
    chk({30'h0, irq, pinIrqReq}, 32'h1, "masked");
    w(`PCINT_IDX_IRQ_CLEAR, 8'h01);
    expect_reg(`PCINT_IDX_IRQ_STATUS, 8'h00);
    expect_reg(`PCINT_IDX_IRQ_CLEAR, 8'h00);
    w(`PCINT_IDX_FLAGS, 8'hFE);
    w(`PCINT_IDX_IRQ_ENABLE, 8'h01);
    @(posedge sys_clk);
    chk({30'h0, irq, pinIrqReq}, 32'h0, "cleared");
    $display("test interrupt done");
    end_sim();
  end
endmodule

`default_nettype wire
